// file: core/dvf_params.svh
// Constants for the data-valid and field-flag output block.
// Assumes inclusion by the design module only.
`ifndef DVF_PARAMS_SVH
`define DVF_PARAMS_SVH
`define DVF_VPS_LINE 9'h010
`define DVF_HT_N_BYTES 5'h10
`define DVF_HT_FIRST_RD 5'h05
`define DVF_HT_A_TX_BASE 6'h1A
`define DVF_HT_B_FIRST_RD 5'h09
`define DVF_HT_B_TX_BASE 6'h0E
`define DVF_HT_LAST_RD 5'h10
`define DVF_FIRST_TX 6'h0E
`define DVF_LAST_TX 6'h1D
`define DVF_DAV_RST 1'h1
`define DVF_FIELD_RST 1'h0
`define DVF_RD_RST 8'h00
`define DVF_RD_BLANK 8'h00
`define DVF_BYTE_MSB 3'h7
`endif

// file: core/dvf_pkg.sv
// Types for the data-valid and field-flag output block.
// Assumes dvf_params.svh sits in the include path.
package dvf_pkg;
	typedef enum logic [1:0] {
		DVF_MODE_VPS,
		DVF_MODE_P2,
		DVF_MODE_P1,
		DVF_MODE_HT
	} dvf_mode_e;

	// Line decoder outputs; field_start and line_start are synchronous one-cycle pulses
	typedef struct packed {
		logic field_start;
		logic first_field;
		logic line_start;
		logic [8:0] line_num;
	} dvf_sync_s;

	typedef struct packed {
		logic vps_ok;
		logic p2_ok;
		logic p1_ok;
		logic hdr_ok;
	} dvf_valid_s;

	// One received transmission byte with its position in the packet
	typedef struct packed {
		logic wr;
		logic [5:0] idx;
		logic [7:0] data;
	} dvf_byte_s;
endpackage

// file: core/dvf_outputs.sv
// Data-valid and first-field flag outputs plus header-time byte ordering.
// Assumes sync, line validity, slicer bytes and I2C stop strobe are
// one-cycle pulses synchronous to ref_clk_i from neighbouring blocks.
//
// Function
// RQ1: Data valid goes low in the line carrying valid data of the selected mode (line 16 for VPS).
// RQ2: In VPS mode data valid returns high at the start of line 16, before that line is evaluated.
// RQ3: In PDC modes data valid returns high at the beginning of the next field.
// RQ4: Data valid is forced high at the stop condition of any I2C access.
// RQ5: The field flag goes high at the beginning of the first field.
// RQ6: The field flag goes low at the beginning of the second field.
// RQ7: With test select high both outputs copy the auxiliary select input.
// RQ8: Header-time read bytes 5 to 8 carry transmission bytes 26 to 29, bit-reversed.
// RQ9: Header-time read bytes 9 to 16 carry transmission bytes 14 to 21, bit-reversed.
// RQ10: After reset data valid stays high until the first valid data line.
`include "dvf_params.svh"
module dvf_outputs (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire dvf_pkg::dvf_mode_e mode_i,
	input wire dvf_pkg::dvf_sync_s sync_i,
	input wire dvf_pkg::dvf_valid_s valid_i,
	input wire dvf_pkg::dvf_byte_s rx_byte_i,
	input wire logic i2c_stop_i,
	input wire logic test_select_in_i,
	input wire logic aux_select_in_i,
	input wire logic [4:0] rd_index_i,
	output logic data_valid_n_out_o,
	output logic first_field_flag_out_o,
	output logic [7:0] rd_data_o
);
	logic dav_n_reg;
	logic dav_n_next;
	logic field_reg;
	logic field_next;
	logic dav_n_out_reg;
	logic field_out_reg;
	logic [7:0] rd_data_reg;
	logic [7:0] ht_mem [`DVF_FIRST_TX:`DVF_LAST_TX];

	wire logic is_vps = (mode_i == dvf_pkg::DVF_MODE_VPS);
	wire logic vps_line = sync_i.line_start && (sync_i.line_num == `DVF_VPS_LINE);
	wire logic clr_vps = is_vps && vps_line; // RQ2
	wire logic clr_pdc = !is_vps && sync_i.field_start; // RQ3
	wire logic mode_ok =
		(mode_i == dvf_pkg::DVF_MODE_VPS) ? valid_i.vps_ok :
		(mode_i == dvf_pkg::DVF_MODE_P2) ? valid_i.p2_ok :
		(mode_i == dvf_pkg::DVF_MODE_P1) ? valid_i.p1_ok : valid_i.hdr_ok; // RQ1

	// Stop condition wins over new data: host must see a fresh edge later
	always_comb begin
		dav_n_next = dav_n_reg;
		if (clr_vps || clr_pdc)
			dav_n_next = 1'h1;
		if (mode_ok)
			dav_n_next = 1'h0; // RQ1
		if (i2c_stop_i)
			dav_n_next = 1'h1; // RQ4
	end

	always_comb begin
		field_next = field_reg;
		if (sync_i.field_start)
			field_next = sync_i.first_field; // RQ5 RQ6
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dav_n_reg <= `DVF_DAV_RST; // RQ10
			field_reg <= `DVF_FIELD_RST;
		end else begin
			dav_n_reg <= dav_n_next;
			field_reg <= field_next;
		end
	end

	// Test select muxes the registered copy so outputs stay flop-driven
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dav_n_out_reg <= `DVF_DAV_RST; // RQ10
			field_out_reg <= `DVF_FIELD_RST;
		end else begin
			dav_n_out_reg <= test_select_in_i ? aux_select_in_i : dav_n_next; // RQ7
			field_out_reg <= test_select_in_i ? aux_select_in_i : field_next; // RQ7
		end
	end

	wire logic store_tx = rx_byte_i.wr && (rx_byte_i.idx >= `DVF_FIRST_TX) && (rx_byte_i.idx <= `DVF_LAST_TX);

	always_ff @(posedge ref_clk_i) begin
		if (store_tx)
			ht_mem[rx_byte_i.idx] <= rx_byte_i.data;
	end

	wire logic in_a = (rd_index_i >= `DVF_HT_FIRST_RD) && (rd_index_i < `DVF_HT_B_FIRST_RD);
	wire logic in_b = (rd_index_i >= `DVF_HT_B_FIRST_RD) && (rd_index_i <= `DVF_HT_LAST_RD);
	wire logic [5:0] tx_a = `DVF_HT_A_TX_BASE + 6'(rd_index_i - `DVF_HT_FIRST_RD); // RQ8
	wire logic [5:0] tx_b = `DVF_HT_B_TX_BASE + 6'(rd_index_i - `DVF_HT_B_FIRST_RD); // RQ9
	wire logic [7:0] raw = in_a ? ht_mem[tx_a] : in_b ? ht_mem[tx_b] : `DVF_RD_BLANK;
	logic [7:0] rev;

	// Transmission bit 0 lands in read bit 7
	generate
		for (genvar b = 0; b <= `DVF_BYTE_MSB; b++) begin : g_rev
			assign rev[`DVF_BYTE_MSB - b] = raw[b]; // RQ8 RQ9
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rd_data_reg <= `DVF_RD_RST;
		else
			rd_data_reg <= (mode_i == dvf_pkg::DVF_MODE_HT) ? rev : `DVF_RD_BLANK;
	end

	assign data_valid_n_out_o = dav_n_out_reg;
	assign first_field_flag_out_o = field_out_reg;
	assign rd_data_o = rd_data_reg;

	property p_stop_high;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(i2c_stop_i && !test_select_in_i) |=> data_valid_n_out_o;
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop did not raise data valid"); // RQ4

	property p_set_low;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(mode_ok && !i2c_stop_i && !test_select_in_i) |=> !data_valid_n_out_o;
	endproperty
	a_set_low: assert property (p_set_low) else $error("valid data did not lower data valid"); // RQ1

	property p_vps_clear;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(clr_vps && !valid_i.vps_ok && !test_select_in_i) |=> data_valid_n_out_o;
	endproperty
	a_vps_clear: assert property (p_vps_clear) else $error("line 16 start did not clear"); // RQ2

	property p_pdc_clear;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(clr_pdc && !mode_ok && !test_select_in_i) |=> data_valid_n_out_o;
	endproperty
	a_pdc_clear: assert property (p_pdc_clear) else $error("field start did not clear"); // RQ3

	property p_first_field;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(sync_i.field_start && sync_i.first_field && !test_select_in_i) |=> first_field_flag_out_o;
	endproperty
	a_first_field: assert property (p_first_field) else $error("flag not high in first field"); // RQ5

	property p_second_field;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(sync_i.field_start && !sync_i.first_field && !test_select_in_i) |=> !first_field_flag_out_o;
	endproperty
	a_second_field: assert property (p_second_field) else $error("flag not low in second field"); // RQ6

	property p_test_copy;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		test_select_in_i |=> (data_valid_n_out_o == $past(aux_select_in_i))
			&& (first_field_flag_out_o == $past(aux_select_in_i));
	endproperty
	a_test_copy: assert property (p_test_copy) else $error("test mode not copying aux input"); // RQ7

	property p_hold_idle;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(!mode_ok && !test_select_in_i && dav_n_reg) |=> data_valid_n_out_o;
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("data valid fell without valid data"); // RQ10

	// Steps shared by the multi-cycle checks below
	sequence s_data_in;
		mode_ok && !i2c_stop_i && !test_select_in_i;
	endsequence

	sequence s_dav_quiet;
		!mode_ok && !i2c_stop_i && !clr_vps && !clr_pdc && !test_select_in_i;
	endsequence

	sequence s_field_idle;
		!sync_i.field_start && !test_select_in_i;
	endsequence

	// A low level must stand until a clear or a stop arrives
	property p_low_stands;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_data_in ##1 s_dav_quiet |=> !data_valid_n_out_o;
	endproperty
	a_low_stands: assert property (p_low_stands) else $error("data valid did not stay low"); // RQ1

	property p_field_stands;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_field_idle ##1 s_field_idle |=> $stable(first_field_flag_out_o);
	endproperty
	a_field_stands: assert property (p_field_stands) else $error("field flag moved mid field"); // RQ5 RQ6

	// Test mode hides the state but must not freeze it
	property p_test_state;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(test_select_in_i && mode_ok && !i2c_stop_i) |=> !dav_n_reg;
	endproperty
	a_test_state: assert property (p_test_state) else $error("state froze in test mode"); // RQ7

	// Checked without disable so the released values are seen
	property p_reset_vals;
		@(posedge ref_clk_i)
		$rose(reset_n_i) |-> (data_valid_n_out_o == `DVF_DAV_RST)
			&& (first_field_flag_out_o == `DVF_FIELD_RST)
			&& (rd_data_o == `DVF_RD_RST);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("outputs not at reset values after release"); // RQ10

	// Bytes outside the mapped window, or any other mode, read blank
	property p_blank_mode;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(mode_i != dvf_pkg::DVF_MODE_HT) |=> (rd_data_o == `DVF_RD_BLANK);
	endproperty
	a_blank_mode: assert property (p_blank_mode) else $error("read data not blank outside header time"); // RQ8 RQ9

	property p_blank_index;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(mode_i == dvf_pkg::DVF_MODE_HT)
			&& ((rd_index_i < `DVF_HT_FIRST_RD) || (rd_index_i > `DVF_HT_LAST_RD))
			|=> (rd_data_o == `DVF_RD_BLANK);
	endproperty
	a_blank_index: assert property (p_blank_index) else $error("unmapped read byte not blank"); // RQ8 RQ9
endmodule

// file: tb/dvf_host_model.sv
// Host model: addresses one read byte, then ends the access with a stop.
// Assumes requests from the bench just after falling edges.
module dvf_host_model (
	input wire logic ref_clk_i,
	input wire logic go_i,
	input wire logic [4:0] want_i,
	output logic stop_o,
	output logic [4:0] rd_index_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic go_q = 1'h0;
	initial stop_o = 1'h0;
	initial rd_index_o = 5'h00;
	always @(posedge ref_clk_i) begin
		stop_o <= go_q & ~go_i;
		// Released index changes every cycle so stale reads show
		rd_index_o <= go_i ? want_i : ~rd_index_o;
		go_q <= go_i;
	end
endmodule

// file: tb/dvf_outputs_tb_top.sv
// Bench for dvf_outputs: directed stimulus, host model, checks.
// Assumes core files and the host model compiled first.
module dvf_outputs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, rst_n = 1'h0, ts = 1'h0, aux = 1'h0, go = 1'h0, stop, dv, ff, e_dv = 1'h1, e_ff = 1'h0;
	dvf_pkg::dvf_mode_e mode = dvf_pkg::DVF_MODE_VPS;
	dvf_pkg::dvf_sync_s sy = '0;
	dvf_pkg::dvf_valid_s va = '0;
	dvf_pkg::dvf_byte_s rx = '0;
	logic [4:0] want = 5'h05, idx;
	logic [7:0] rd, ex, mem [$];
	logic [15:0] lf = 16'h33FB;
	int fails = 0, checks_done = 0, tx, held = 1;
	dvf_outputs DUT (.ref_clk_i(clk), .reset_n_i(rst_n), .mode_i(mode), .sync_i(sy), .valid_i(va),
		.rx_byte_i(rx), .i2c_stop_i(stop), .test_select_in_i(ts), .aux_select_in_i(aux),
		.rd_index_i(idx), .data_valid_n_out_o(dv), .first_field_flag_out_o(ff), .rd_data_o(rd));
	dvf_host_model host (.ref_clk_i(clk), .go_i(go), .want_i(want), .stop_o(stop), .rd_index_o(idx));
	initial forever #5 clk = ~clk;
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task step(input int n = 1);
		repeat (n) @(negedge clk);
	endtask
	task outs;
		chk("data_valid_n", {7'h00, dv}, {7'h00, e_dv});
		chk("first_field", {7'h00, ff}, {7'h00, e_ff});
	endtask
	task host_read(input logic [4:0] n, input logic [7:0] exp);
		want = n;
		go = 1'h1;
		step();
		go = 1'h0;
		step();
		chk("rd_data", rd, exp);
		step();
		e_dv = 1'h1;
		outs();
	endtask
	task results;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		results();
	end
	initial begin
		step(8);
		rst_n = 1'h1;
		outs();
		va.vps_ok = 1'h1;
		step();
		va = '0;
		e_dv = 1'h0;
		outs();
		for (int l = 15; l < 17; l++) begin
			sy.line_num = 9'(l);
			sy.line_start = 1'h1;
			step();
			sy.line_start = 1'h0;
			e_dv = (l == 16);
			outs();
		end
		va.vps_ok = 1'h1;
		step();
		va = '0;
		e_dv = 1'h0;
		host_read(5'h01, 8'h00);
		$display("vps test done");
		for (int m = 1; m < 4; m++) begin
			mode = dvf_pkg::dvf_mode_e'(m);
			va = 4'(1 << (3 - m));
			step();
			va = '0;
			e_dv = 1'h0;
			outs();
			sy.first_field = m[0];
			sy.field_start = 1'h1;
			step();
			sy.field_start = 1'h0;
			e_dv = 1'h1;
			e_ff = m[0];
			outs();
		end
		$display("pdc test done");
		for (int i = 14; i < 30; i++) begin
			lf = nx(lf);
			mem.push_back(lf[7:0]);
			rx = {1'h1, 6'(i), mem[$]};
			step();
		end
		rx = '0;
		for (int k = 4; k < 17; k++) begin
			tx = k < 9 ? k + 21 : k + 5;
			ex = {<<{mem[tx - 14]}};
			host_read(5'(k), k < 5 ? 8'h00 : ex);
		end
		$display("header time test done");
		ts = 1'h1;
		repeat (8) begin
			lf = nx(lf);
			aux = lf[0];
			va.hdr_ok = lf[1];
			if (lf[1]) held = 0;
			step();
			e_dv = aux;
			e_ff = aux;
			outs();
		end
		ts = 1'h0;
		va = '0;
		step();
		e_dv = held[0];
		e_ff = 1'h1;
		outs();
		$display("test mode test done");
		results();
	end
endmodule
